// ===== tb/ppg_parallel_port_sva.sv
// Purpose: Port-level checks of the parallel port group.
// Assumes: Control word tracked from mode-set writes to E7.
// Notes: Bound to every instance of the port group.
`timescale 1ns/1ps
module ppg_parallel_port_sva (
  input wire clock,
  input wire reset,
  input wire [7:0] ioAddr,
  input wire ioWrite,
  input wire ioRead,
  input wire [7:0] ioWdata,
  input wire [7:0] ioRdata,
  input wire [7:0] paOut,
  input wire paOeN,
  input wire [7:0] pcIn,
  input wire [7:0] pcOut,
  input wire [7:0] pcOeN,
  input wire portAFifoReady,
  input wire boardIrqLineN
);
  // ----
  // Mode tracking
  // ----
  reg [7:0] ctrlWord_r;
  wire aOut1 = ctrlWord_r[7:4] == 4'hA;
  wire aIn1 = ctrlWord_r[7:4] == 4'hB;
  wire aBi = ctrlWord_r[6];
  always @(posedge clock) begin
    if (reset) begin
      ctrlWord_r <= 8'h9B;
    end else if (ioWrite && ioAddr == 8'hE7 && ioWdata[7]) begin
      ctrlWord_r <= ioWdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence aWrite;
    aOut1 && ioWrite && ioAddr == 8'hE4 && pcIn[6];
  endsequence
  sequence ackFall;
    aOut1 && $fell(pcIn[6]) && !ioWrite;
  endsequence
  // ----
  // Assertions
  // ----
  reset_quiet_a: assert property (disable iff (1'b0) reset |=> paOeN && boardIrqLineN)
    else $error("port drive or interrupt active after reset");
  read_zero_a: assert property (ioRead && (ioAddr == 8'hE7 || ioAddr < 8'hE4) |=> !ioRdata)
    else $error("control or unmapped read not zero");
  write_full_a: assert property (aWrite |=> !pcOut[7] && paOut == ~$past(ioWdata))
    else $error("port A write did not latch inverted byte with full flag");
  ack_release_a: assert property (ackFall |=> pcOut[7])
    else $error("acknowledge did not release output full");
  strobe_full_a: assert property ((aIn1 || aBi) && $fell(pcIn[4]) && portAFifoReady |=> pcOut[5])
    else $error("strobe did not set input full");
  bidir_dir_a: assert property (aBi |-> paOeN == pcIn[6])
    else $error("bidirectional drive does not follow acknowledge");
  in1_pins_a: assert property (aIn1 |-> !pcOeN[3] && pcOeN[4] && !pcOeN[5])
    else $error("strobed input handshake pin directions wrong");
  out1_pins_a: assert property (aOut1 |-> !pcOeN[3] && pcOeN[6] && !pcOeN[7])
    else $error("latched output handshake pin directions wrong");
  bidir_pins_a: assert property (aBi |-> pcOeN[7:3] == 5'b01010)
    else $error("bidirectional handshake pin directions wrong");
  bhand_pins_a: assert property (ctrlWord_r[2] && !aBi |-> !pcOeN[0] && !pcOeN[1] && pcOeN[2])
    else $error("port B handshake pin directions wrong");
  c_whole_a: assert property (ctrlWord_r[6:5] == 2'b00 && !ctrlWord_r[2] |-> pcOeN == {8{ctrlWord_r[0]}})
    else $error("port C not one direction as a whole");
  bstrobe_full_a: assert property (ctrlWord_r[2:1] == 2'b11 && !aBi && $fell(pcIn[2]) |=> pcOut[1])
    else $error("port B strobe did not set input full");
endmodule

bind ppg_parallel_port ppg_parallel_port_sva chk (.clock(clock), .reset(reset), .ioAddr(ioAddr),
  .ioWrite(ioWrite), .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .paOut(paOut),
  .paOeN(paOeN), .pcIn(pcIn), .pcOut(pcOut), .pcOeN(pcOeN), .portAFifoReady(portAFifoReady),
  .boardIrqLineN(boardIrqLineN));

// ===== tb/ppg_parallel_port_tb_top.sv
// Purpose: Directed bench for the parallel port group.
// Assumes: Peripheral model drives every pin input.
// Notes: Inputs change at the falling clock edge.
`timescale 1ns/1ps
module ppg_parallel_port_tb_top;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg [7:0] ioAddr = 8'h00;
  reg ioWrite = 1'b0;
  reg ioRead = 1'b0;
  reg [7:0] ioWdata = 8'h00;
  wire [7:0] ioRdata, paIn, paOut, pbIn, pbOut, pcIn, pcOut, pcOeN;
  wire paOeN, pbOeN, portAFifoReady, boardIrqLineN;
  integer failCount = 0;
  integer checked = 0;
  integer i;
  reg [7:0] d;
  initial begin
    forever #2 clock = ~clock;
  end
  ppg_parallel_port dut (.clock(clock), .reset(reset), .ioAddr(ioAddr), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .paIn(paIn), .paOut(paOut),
    .paOeN(paOeN), .pbIn(pbIn), .pbOut(pbOut), .pbOeN(pbOeN), .pcIn(pcIn), .pcOut(pcOut),
    .pcOeN(pcOeN), .portAFifoReady(portAFifoReady), .boardIrqLineN(boardIrqLineN));
  ppg_peripheral_model peer (.clock(clock), .paOut(paOut), .paOeN(paOeN), .pbOut(pbOut),
    .pbOeN(pbOeN), .pcOut(pcOut), .pcOeN(pcOeN), .paIn(paIn), .pbIn(pbIn), .pcIn(pcIn));
  // ----
  // Access and compare tasks
  // ----
  task ioWr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clock);
      ioAddr = a;
      ioWdata = v;
      ioWrite = 1'b1;
      @(negedge clock);
      ioWrite = 1'b0;
    end
  endtask
  task ioRd(input [7:0] a, output [7:0] v);
    begin
      @(negedge clock);
      ioAddr = a;
      ioRead = 1'b1;
      @(negedge clock);
      ioRead = 1'b0;
      v = ioRdata;
    end
  endtask
  task chk8(input [7:0] g, input [7:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failCount = failCount + 1;
        $display("Error at %0t: byte %h, expected %h", $time, g, e);
      end
    end
  endtask
  task chk1(input g, input e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failCount = failCount + 1;
        $display("Error at %0t: flag %b, expected %b", $time, g, e);
      end
    end
  endtask
  task endOfTest;
    begin
      $display("Checks %0d, errors %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (4000) @(posedge clock);
    failCount = failCount + 1;
    endOfTest;
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (5) @(negedge clock);
    reset = 1'b0;
    chk1(paOeN, 1'b1);
    chk8(pcOeN, 8'hFF);
    chk1(boardIrqLineN, 1'b1);
    ioRd(8'hE7, d);
    chk8(d, 8'h00);
    ioRd(8'hE3, d);
    chk8(d, 8'h00);
    peer.drive(8'h3C);
    ioRd(8'hE4, d);
    chk8(d, 8'hC3);
    peer.releaseBus;
    peer.pb_r = 8'h96;
    ioWr(8'hE7, 8'h82);
    chk1(pbOeN, 1'b1);
    ioRd(8'hE5, d);
    chk8(d, 8'h96);
    ioWr(8'hE4, 8'h3C);
    chk8(paOut, 8'hC3);
    chk1(paOeN, 1'b0);
    ioWr(8'hE7, 8'h80);
    ioWr(8'hE5, 8'h5A);
    chk8(pbOut, 8'h5A);
    chk1(pbOeN, 1'b0);
    chk8(pcOeN, 8'h00);
    ioWr(8'hE6, 8'hA5);
    chk8(pcOut, 8'hA5);
    ioRd(8'hE6, d);
    chk8(d, 8'hA5);
    ioWr(8'hE7, 8'h86);
    chk1(pcOeN[2], 1'b1);
    ioWr(8'hE7, 8'h05);
    peer.strobeB(8'h69);
    chk1(pcOut[1], 1'b1);
    chk1(boardIrqLineN, 1'b0);
    ioRd(8'hE5, d);
    chk8(d, 8'h69);
    chk1(pcOut[1], 1'b0);
    chk1(boardIrqLineN, 1'b1);
    ioWr(8'hE7, 8'hA0);
    ioWr(8'hE7, 8'h0D);
    ioWr(8'hE4, 8'h55);
    chk1(pcOut[7], 1'b0);
    chk8(paOut, 8'hAA);
    peer.ack;
    @(negedge clock);
    chk1(pcOut[7], 1'b1);
    chk1(boardIrqLineN, 1'b0);
    ioWr(8'hE7, 8'hB0);
    ioWr(8'hE7, 8'h09);
    for (i = 0; i < 32; i = i + 1) peer.strobe(i[7:0]);
    chk1(portAFifoReady, 1'b0);
    chk1(pcOut[3], 1'b1);
    peer.strobe(8'hEE);
    for (i = 0; i < 32; i = i + 1) begin
      ioRd(8'hE4, d);
      chk8(d, ~i[7:0]);
    end
    chk1(pcOut[5], 1'b0);
    chk1(pcOut[3], 1'b0);
    ioRd(8'hE4, d);
    chk8(d, 8'h00);
    ioWr(8'hE7, 8'hC0);
    peer.setAck(1'b0);
    chk1(paOeN, 1'b0);
    peer.setAck(1'b1);
    chk1(paOeN, 1'b1);
    peer.strobe(8'h5A);
    ioRd(8'hE4, d);
    chk8(d, 8'hA5);
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    chk1(paOeN, 1'b1);
    chk8(pcOeN, 8'hFF);
    endOfTest;
  end
endmodule

// ===== tb/ppg_peripheral_model.sv
// Purpose: Peripheral on the far side of the port group pins.
// Assumes: Handshake and spare port C lines idle high through pull-ups.
// Notes: Tasks are called by the bench and drive at the falling edge.
`timescale 1ns/1ps
module ppg_peripheral_model (
  input wire clock,
  input wire [7:0] paOut,
  input wire paOeN,
  input wire [7:0] pbOut,
  input wire pbOeN,
  input wire [7:0] pcOut,
  input wire [7:0] pcOeN,
  output wire [7:0] paIn,
  output wire [7:0] pbIn,
  output wire [7:0] pcIn
);
  // ----
  // Pin levels
  // ----
  reg [7:0] bus_r = 8'h00;
  reg busOn_r = 1'b0;
  reg stbN_r = 1'b1;
  reg ackN_r = 1'b1;
  reg bStbN_r = 1'b1;
  reg [7:0] pb_r = 8'h00;
  wire [7:0] peerC = {1'b1, ackN_r, 1'b1, stbN_r, 1'b1, bStbN_r, 2'b11};
  // Released bus shows the inverse of the last byte
  assign paIn = !paOeN ? paOut : (busOn_r ? bus_r : ~bus_r);
  assign pbIn = !pbOeN ? pbOut : pb_r;
  assign pcIn = (pcOut & ~pcOeN) | (peerC & pcOeN);
  task drive(input [7:0] v);
    begin
      @(negedge clock);
      bus_r = v;
      busOn_r = 1'b1;
    end
  endtask
  task releaseBus;
    begin
      @(negedge clock);
      busOn_r = 1'b0;
    end
  endtask
  // Data held through the low strobe and one high cycle
  task strobe(input [7:0] v);
    begin
      @(negedge clock);
      bus_r = v;
      busOn_r = 1'b1;
      stbN_r = 1'b0;
      @(negedge clock);
      stbN_r = 1'b1;
      @(negedge clock);
      busOn_r = 1'b0;
    end
  endtask
  // Port B strobe: data held after the strobe returns high
  task strobeB(input [7:0] v);
    begin
      @(negedge clock);
      pb_r = v;
      bStbN_r = 1'b0;
      @(negedge clock);
      bStbN_r = 1'b1;
    end
  endtask
  task ack;
    begin
      @(negedge clock);
      ackN_r = 1'b0;
      @(negedge clock);
      ackN_r = 1'b1;
    end
  endtask
  task setAck(input b);
    begin
      @(negedge clock);
      ackN_r = b;
      #1;
    end
  endtask
endmodule

// ===== verilog/ppg_map.vh
// Purpose: Address map, control word layout and pin roles of the
//          group-one parallel port block.
// Assumes: Included by its bare name from the design file.
// Notes:   Definitions only.
`ifndef PPG_MAP_VH
`define PPG_MAP_VH

// ----------------------------------------------------------------
// I/O addresses
// ----------------------------------------------------------------
`define PPG_ADDR_PORT_A 8'hE4
`define PPG_ADDR_PORT_B 8'hE5
`define PPG_ADDR_PORT_C 8'hE6
`define PPG_ADDR_CTRL 8'hE7

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define PPG_CW_SET 7
`define PPG_CW_A_MODE_HI 6
`define PPG_CW_A_MODE_LO 5
`define PPG_CW_A_DIR 4
`define PPG_CW_C_UP 3
`define PPG_CW_B_MODE 2
`define PPG_CW_B_DIR 1
`define PPG_CW_C_LOW 0
`define PPG_CW_BSEL_HI 3
`define PPG_CW_BSEL_LO 1
`define PPG_CW_BVAL 0
`define PPG_CW_RESET 8'h9B

// ----------------------------------------------------------------
// Port C pin roles
// ----------------------------------------------------------------
`define PPG_PC_B_IRQ_OUT 0
`define PPG_PC_B_FLAG 1
`define PPG_PC_B_STB 2
`define PPG_PC_A_IRQ_OUT 3
`define PPG_PC_A_STB 4
`define PPG_PC_A_IBF 5
`define PPG_PC_A_ACK 6
`define PPG_PC_A_OBF 7

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define PPG_DATA_W 8
`define PPG_FIFO_DEPTH 32
`define PPG_FIFO_AW 5
`define PPG_BYTE_ZERO 8'h00
`define PPG_BYTE_ONES 8'hFF

`endif

// ===== verilog/ppg_parallel_port.v
// Purpose: Group-one parallel port: ports A, B and C behind a
//          control word, with strobed, latched and bidirectional modes.
// Assumes: One clock, synchronous active-high reset, pins synchronous.
// Notes:   Strobed port A input bytes queue in a 32-word FIFO.
//
// Summary of operation
// R1: Decode A E4, B E5, control E7.
// R2: Port A offers five mode/direction configurations.
// R3: B mode 0/1 only; A mode 2 forces 0.
// R4: Port A pin data inverted from processor value.
// R5: Mode 2: acknowledge high input, low drive.
// R6: Strobed A: C3 irq, C4 strobe, C5 full.
// R7: Latched A: C3 irq, C6 ack, C7 full.
// R8: Mode 2: C3..C7 handshake; C0-1 free, C2 input.
// R9: B mode 1 claims C0, C1, C2.
// R10: C eight-bit path only when unclaimed.
// R11: Control 1xxxx01x selects B mode 0 input.
// R12: Control 1010xxxx selects A mode 1 output.
// R13: Control 11xxxxxx selects A mode 2.
// R14: Processor writes control word before port use.
// R15: Port C never split into nibble directions; latched A with B mode 0 takes C5 direction from bit 3, C0-C2 from bit 0.
// R16: Strobe low latches byte; read clears full, irq; port A full and input irq stay set until its FIFO is empty.
// R17: Write asserts full; ack releases it, raises irq.
// R18: Reset gives mode 0 input, handshakes inactive.
`timescale 1ns/1ps
`include "ppg_map.vh"

// ----------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------
module ppg_fifo #(
  parameter WIDTH = `PPG_DATA_W,
  parameter DEPTH = `PPG_FIFO_DEPTH,
  parameter AW = `PPG_FIFO_AW
) (
  input wire clock,
  input wire reset,
  input wire flush,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  localparam [AW:0] FULL_COUNT = DEPTH;

  assign inReady = (count_r != FULL_COUNT);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_r];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always @(posedge clock) begin
    if (reset || flush) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// Port group
// ----------------------------------------------------------------
module ppg_parallel_port (
  input wire clock,
  input wire reset,
  input wire [7:0] ioAddr,
  input wire ioWrite,
  input wire ioRead,
  input wire [7:0] ioWdata,
  output reg [7:0] ioRdata,
  input wire [7:0] paIn,
  output wire [7:0] paOut,
  output wire paOeN,
  input wire [7:0] pbIn,
  output wire [7:0] pbOut,
  output wire pbOeN,
  input wire [7:0] pcIn,
  output wire [7:0] pcOut,
  output wire [7:0] pcOeN,
  output wire portAFifoReady,
  output wire boardIrqLineN
);
  reg [7:0] cw_r, paLatch_r, pbLatch_r, pbInLatch_r, pcLatch_r;
  reg aObfN_r, aOutIntr_r, bIbf_r, bObfN_r, bOutIntr_r;
  reg inteAIn_r, inteAOut_r, inteB_r, aStbPrev_r, aAckPrev_r, bStbPrev_r;
  reg [7:0] dedDrive, dedVal, freeDrive;
  wire aMode2, aMode1, aMode0, aIn, bMode1, bIn, cIn, aInHs, aOutHs;
  wire aStbFall, aAckFall, bStbFall, wrA, wrB, wrC, wrCtrl, rdA, rdB;
  wire fifoValid, intrA, intrB, bIntrLevel;
  wire [7:0] fifoData, drvMask, pcView;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign aMode2 = cw_r[`PPG_CW_A_MODE_HI]; // R13
  assign aMode1 = !cw_r[`PPG_CW_A_MODE_HI] & cw_r[`PPG_CW_A_MODE_LO]; // R12
  assign aMode0 = !cw_r[`PPG_CW_A_MODE_HI] & !cw_r[`PPG_CW_A_MODE_LO]; // R2
  assign aIn = cw_r[`PPG_CW_A_DIR];
  assign bMode1 = cw_r[`PPG_CW_B_MODE] & !aMode2; // R3
  assign bIn = cw_r[`PPG_CW_B_DIR]; // R11
  assign cIn = cw_r[`PPG_CW_C_LOW]; // R15
  assign aInHs = (aMode1 & aIn) | aMode2;
  assign aOutHs = (aMode1 & !aIn) | aMode2;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wrA = ioWrite & (ioAddr == `PPG_ADDR_PORT_A); // R1
  assign wrB = ioWrite & (ioAddr == `PPG_ADDR_PORT_B); // R1
  assign wrC = ioWrite & (ioAddr == `PPG_ADDR_PORT_C);
  assign wrCtrl = ioWrite & (ioAddr == `PPG_ADDR_CTRL); // R1
  assign rdA = ioRead & (ioAddr == `PPG_ADDR_PORT_A);
  assign rdB = ioRead & (ioAddr == `PPG_ADDR_PORT_B);

  // ----------------------------------------------------------------
  // Handshake edges
  // ----------------------------------------------------------------
  assign aStbFall = aInHs & aStbPrev_r & !pcIn[`PPG_PC_A_STB];
  assign aAckFall = aOutHs & aAckPrev_r & !pcIn[`PPG_PC_A_ACK];
  assign bStbFall = bMode1 & bStbPrev_r & !pcIn[`PPG_PC_B_STB];

  // Strobed bytes queue; a strobe while full is dropped
  ppg_fifo #(
    .WIDTH(`PPG_DATA_W),
    .DEPTH(`PPG_FIFO_DEPTH),
    .AW(`PPG_FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .flush(wrCtrl & ioWdata[`PPG_CW_SET]),
    .inValid(aStbFall), // R16
    .inReady(portAFifoReady),
    .inData(~paIn), // R4
    .outValid(fifoValid),
    .outReady(rdA & aInHs), // R16
    .outData(fifoData)
  );

  // ----------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      cw_r <= `PPG_CW_RESET; // R18
      paLatch_r <= `PPG_BYTE_ZERO;
      pbLatch_r <= `PPG_BYTE_ZERO;
      pbInLatch_r <= `PPG_BYTE_ZERO;
      pcLatch_r <= `PPG_BYTE_ZERO;
      aObfN_r <= 1'b1; // R18
      aOutIntr_r <= 1'b0;
      bIbf_r <= 1'b0;
      bObfN_r <= 1'b1;
      bOutIntr_r <= 1'b0;
      inteAIn_r <= 1'b0;
      inteAOut_r <= 1'b0;
      inteB_r <= 1'b0;
      aStbPrev_r <= 1'b1;
      aAckPrev_r <= 1'b1;
      bStbPrev_r <= 1'b1;
    end else begin
      aStbPrev_r <= pcIn[`PPG_PC_A_STB];
      aAckPrev_r <= pcIn[`PPG_PC_A_ACK];
      bStbPrev_r <= pcIn[`PPG_PC_B_STB];
      if (wrCtrl && ioWdata[`PPG_CW_SET]) begin
        // Mode set: B mode bit dropped when A goes to mode 2
        cw_r <= {ioWdata[`PPG_CW_SET:`PPG_CW_C_UP],
                 ioWdata[`PPG_CW_B_MODE] & !ioWdata[`PPG_CW_A_MODE_HI],
                 ioWdata[`PPG_CW_B_DIR:`PPG_CW_C_LOW]}; // R3
        pcLatch_r <= `PPG_BYTE_ZERO;
        aObfN_r <= 1'b1;
        aOutIntr_r <= 1'b0;
        bIbf_r <= 1'b0;
        bObfN_r <= 1'b1;
        bOutIntr_r <= 1'b0;
        inteAIn_r <= 1'b0;
        inteAOut_r <= 1'b0;
        inteB_r <= 1'b0;
      end else begin
        if (wrCtrl) begin
          // Single bit set/reset of port C, also steers interrupt enables
          pcLatch_r[ioWdata[`PPG_CW_BSEL_HI:`PPG_CW_BSEL_LO]] <=
            ioWdata[`PPG_CW_BVAL];
          if (ioWdata[`PPG_CW_BSEL_HI:`PPG_CW_BSEL_LO] == `PPG_PC_A_STB) begin
            inteAIn_r <= ioWdata[`PPG_CW_BVAL];
          end
          if (ioWdata[`PPG_CW_BSEL_HI:`PPG_CW_BSEL_LO] == `PPG_PC_A_ACK) begin
            inteAOut_r <= ioWdata[`PPG_CW_BVAL];
          end
          if (ioWdata[`PPG_CW_BSEL_HI:`PPG_CW_BSEL_LO] == `PPG_PC_B_STB) begin
            inteB_r <= ioWdata[`PPG_CW_BVAL];
          end
        end
        if (wrC) begin
          pcLatch_r <= ioWdata;
        end
        if (wrA) begin
          paLatch_r <= ioWdata;
          if (aOutHs) begin
            aObfN_r <= 1'b0; // R17
            aOutIntr_r <= 1'b0;
          end
        end
        // Acknowledge after a write in the same cycle wins
        if (aAckFall) begin
          aObfN_r <= 1'b1; // R17
          aOutIntr_r <= 1'b1; // R17
        end
        if (wrB) begin
          pbLatch_r <= ioWdata;
          if (bMode1 && !bIn) begin
            bObfN_r <= 1'b0;
            bOutIntr_r <= 1'b0;
          end
        end
        if (bMode1 && !bIn && bStbFall) begin
          bObfN_r <= 1'b1;
          bOutIntr_r <= 1'b1;
        end
        if (rdB && bMode1 && bIn) begin
          bIbf_r <= 1'b0; // R16
        end
        // New strobe beats a read in the same cycle
        if (bMode1 && bIn && bStbFall) begin
          pbInLatch_r <= pbIn;
          bIbf_r <= 1'b1; // R16
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign intrA = (aInHs & inteAIn_r & fifoValid) |
                 (aOutHs & inteAOut_r & aOutIntr_r); // R16 R17
  assign bIntrLevel = bIn ? bIbf_r : bOutIntr_r;
  assign intrB = bMode1 & inteB_r & bIntrLevel;
  assign boardIrqLineN = !(intrA | intrB);

  // ----------------------------------------------------------------
  // Port A and B pins
  // ----------------------------------------------------------------
  assign paOut = ~paLatch_r; // R4
  assign paOeN = aMode2 ? pcIn[`PPG_PC_A_ACK] : aIn; // R5
  assign pbOut = pbLatch_r;
  assign pbOeN = bIn;

  // ----------------------------------------------------------------
  // Port C pin roles
  // ----------------------------------------------------------------
  always @* begin
    dedDrive = `PPG_BYTE_ZERO;
    dedVal = `PPG_BYTE_ZERO;
    freeDrive = cIn ? `PPG_BYTE_ZERO : `PPG_BYTE_ONES; // R10 R15
    if (aMode1 && aIn) begin
      dedDrive[`PPG_PC_A_IRQ_OUT] = 1'b1; // R6
      dedVal[`PPG_PC_A_IRQ_OUT] = intrA;
      dedDrive[`PPG_PC_A_IBF] = 1'b1; // R6
      dedVal[`PPG_PC_A_IBF] = fifoValid;
      freeDrive[`PPG_PC_A_OBF:`PPG_PC_A_IRQ_OUT] = 5'h00;
    end else if (aMode1) begin
      dedDrive[`PPG_PC_A_IRQ_OUT] = 1'b1; // R7
      dedVal[`PPG_PC_A_IRQ_OUT] = intrA;
      dedDrive[`PPG_PC_A_OBF] = 1'b1; // R7
      dedVal[`PPG_PC_A_OBF] = aObfN_r;
      freeDrive[`PPG_PC_A_OBF:`PPG_PC_A_IRQ_OUT] = 5'h00;
      freeDrive[`PPG_PC_A_IBF] = !cw_r[`PPG_CW_C_UP]; // R7
    end else if (aMode2) begin
      dedDrive[`PPG_PC_A_IRQ_OUT] = 1'b1; // R8
      dedVal[`PPG_PC_A_IRQ_OUT] = intrA;
      dedDrive[`PPG_PC_A_IBF] = 1'b1;
      dedVal[`PPG_PC_A_IBF] = fifoValid;
      dedDrive[`PPG_PC_A_OBF] = 1'b1;
      dedVal[`PPG_PC_A_OBF] = aObfN_r;
      freeDrive[`PPG_PC_A_OBF:`PPG_PC_A_IRQ_OUT] = 5'h00;
      freeDrive[`PPG_PC_B_STB] = 1'b0; // R8
      freeDrive[`PPG_PC_B_FLAG:`PPG_PC_B_IRQ_OUT] =
        cw_r[`PPG_CW_C_UP] ? 2'h0 : 2'h3;
    end
    if (bMode1) begin
      dedDrive[`PPG_PC_B_IRQ_OUT] = 1'b1; // R9
      dedVal[`PPG_PC_B_IRQ_OUT] = intrB;
      dedDrive[`PPG_PC_B_FLAG] = 1'b1; // R9
      dedVal[`PPG_PC_B_FLAG] = bIn ? bIbf_r : bObfN_r;
      freeDrive[`PPG_PC_B_STB:`PPG_PC_B_IRQ_OUT] = 3'h0; // R9
    end
  end

  genvar i;
  generate
    for (i = 0; i < `PPG_DATA_W; i = i + 1) begin : g_pc
      assign pcOut[i] = dedDrive[i] ? dedVal[i] : pcLatch_r[i];
      assign pcOeN[i] = !(dedDrive[i] | freeDrive[i]);
      assign drvMask[i] = dedDrive[i] | freeDrive[i];
      assign pcView[i] = drvMask[i] ? pcOut[i] : pcIn[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (reset) begin
      ioRdata <= `PPG_BYTE_ZERO;
    end else if (ioRead) begin
      if (ioAddr == `PPG_ADDR_PORT_A) begin
        if (aInHs) begin
          ioRdata <= fifoValid ? fifoData : `PPG_BYTE_ZERO; // R16
        end else if (aIn) begin
          ioRdata <= ~paIn; // R4
        end else begin
          ioRdata <= paLatch_r;
        end
      end else if (ioAddr == `PPG_ADDR_PORT_B) begin
        if (bMode1 && bIn) begin
          ioRdata <= pbInLatch_r;
        end else if (bIn) begin
          ioRdata <= pbIn;
        end else begin
          ioRdata <= pbLatch_r;
        end
      end else if (ioAddr == `PPG_ADDR_PORT_C) begin
        ioRdata <= pcView;
      end else begin
        ioRdata <= `PPG_BYTE_ZERO;
      end
    end
  end
endmodule
